//--- rtl/flash_seq_consts.vh
// Constants for the flash program sequencer: register map, fields, timing.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_FLASH_CTRL 4'h0
`define ADDR_AUX_ONE 4'h4
`define ADDR_AUX 4'h8
`define ADDR_STATUS 4'hC
// ----------------------------------------
// Flash control and auxiliary register fields
// ----------------------------------------
`define FC_BUSY_BIT 0
`define FC_SPACE_LO 1
`define FC_MAP_BIT 3
`define FC_KEY_LO 4
`define KEY_UNLOCK 4'h5
`define KEY_LAUNCH 4'hA
`define SPACE_USER 2'h0
`define SPACE_EXTRA_ROW_SPACE 2'h1
`define SPACE_SEC 2'h2
`define SPACE_RSVD 2'h3
`define AUX_ONE_BOOT_BIT 5
`define AUX_EXT_RAM_SELECT_BIT 1
// ----------------------------------------
// Address ranges
// ----------------------------------------
`define EXTRA_ROW_SPACE_BASE 16'hFF80
`define BOOT_BASE 16'hF400
`define LATCH_TOP 16'h7FFF
// ----------------------------------------
// Timing: page erase and program time in microseconds
// ----------------------------------------
`define ERASE_TIME_US 5000
`define PROG_TIME_US 5000
`define CLK_MHZ 10
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define PAGE_BYTES 128
`endif

//--- rtl/column_latch_mem.v
// Column latch storage: one page of bytes with a per-byte loaded flag.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/1ns
module column_latch_mem #(
  parameter DEPTH = 128,
  parameter AW = 7
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data,
  output reg rd_loaded,
  // Clears every loaded flag after a page has been committed
  input wire clear_all
);
  reg [7:0] mem [0:DEPTH-1];
  reg [DEPTH-1:0] loaded_reg;
  // Data storage needs no reset; only the loaded flags gate use.
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
  // Loaded flags; a write in the clearing cycle still wins.
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_flag
      always @(posedge aclk) begin
        if (!aresetn) begin
          loaded_reg[i] <= 1'b0;
        end else if (wr_en && wr_addr == i) begin
          loaded_reg[i] <= 1'b1;
        end else if (clear_all) begin
          loaded_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_loaded <= 1'b0;
    end else begin
      rd_loaded <= loaded_reg[rd_addr];
    end
  end
endmodule

//--- rtl/flash_program_sequencer.v
// Flash program sequencer: control registers, latch mapping, unlock and
// timed erase/program of loaded bytes, code-space read steering.
// Assumes the CPU core presents data writes and code reads as one-cycle
// strobes on aclk, and software reaches registers over AXI4-Lite.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "flash_seq_consts.vh"
module flash_program_sequencer #(
  parameter ERASE_CYCLES = `ERASE_CYCLES,
  parameter PROG_CYCLES = `PROG_CYCLES,
  parameter BOOT_DEPTH = 3072
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // CPU data-space write strobe
  input wire data_wr,
  input wire [15:0] data_pointer,
  input wire [7:0] data_wdata,
  // Steered data write toward external or expanded RAM
  output reg xram_wr,
  output reg [15:0] xram_addr,
  output reg [7:0] xram_wdata,
  // CPU code-space read request; answer one cycle later
  input wire code_rd,
  input wire [15:0] code_addr,
  output reg code_valid,
  output reg [7:0] code_rdata,
  // Idle hold toward the CPU
  output reg cpu_idle
);
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg latch_map_select_reg;
  reg [1:0] space_select_reg;
  reg [3:0] last_key_reg;
  reg program_busy_reg;
  reg boot_space_select_reg;
  reg ext_ram_select_reg;
  reg [7:0] security_reg;
  reg [7:0] page_reg;
  reg [1:0] target_reg;
  // ----------------------------------------
  // Storage arrays
  // ----------------------------------------
  reg [7:0] user_mem [0:32767];
  reg [7:0] extra_row_space_mem [0:`PAGE_BYTES-1];
  reg [7:0] boot_mem [0:BOOT_DEPTH-1];
  // Boot image is loaded outside this block; zeros stand in for it.
  integer bi;
  initial begin
    for (bi = 0; bi < BOOT_DEPTH; bi = bi + 1) boot_mem[bi] = 8'h00;
  end
  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg [3:0] aw_hold_reg;
  reg aw_have_reg;
  reg [31:0] w_hold_reg;
  reg [3:0] ws_hold_reg;
  reg w_have_reg;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire [3:0] wr_a = aw_fire ? s_axi_awaddr : aw_hold_reg;
  wire [31:0] wr_d = w_fire ? s_axi_wdata : w_hold_reg;
  wire [3:0] wr_s = w_fire ? s_axi_wstrb : ws_hold_reg;
  wire wr_go = (aw_fire || aw_have_reg) && (w_fire || w_have_reg) &&
    !s_axi_bvalid;
  wire wr_lane0 = wr_go && wr_s[0];
  // Address and data are taken in either order and held until paired.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_hold_reg <= 4'h0;
      w_hold_reg <= 32'h00000000;
      ws_hold_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_reg && !aw_fire && !wr_go;
      s_axi_wready <= !w_have_reg && !w_fire && !wr_go;
      if (aw_fire) begin
        aw_hold_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_hold_reg <= s_axi_wdata;
        ws_hold_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Writes to the STATUS address answer with a slave error; other addresses answer OKAY.
        s_axi_bresp <= (wr_a == `ADDR_STATUS) ? 2'h2 : 2'h0;
      end else begin
        if (aw_fire) begin
          aw_have_reg <= 1'b1;
        end
        if (w_fire) begin
          w_have_reg <= 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end
  // Read path: one answer per address, held until rready.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `ADDR_FLASH_CTRL: s_axi_rdata <= {24'h000000, last_key_reg,
            latch_map_select_reg, space_select_reg,
            program_busy_reg};
          `ADDR_AUX_ONE: s_axi_rdata <= {26'h0000000,
            boot_space_select_reg, 5'h00};
          `ADDR_AUX: s_axi_rdata <= {30'h00000000,
            ext_ram_select_reg, 1'b0};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Unlock sequence and control bits
  // ----------------------------------------
  wire ctrl_wr = wr_lane0 && wr_a == `ADDR_FLASH_CTRL;
  wire [3:0] key = wr_d[7:4];
  wire [1:0] new_space = wr_d[2:1];
  // Launch only when A directly follows 5 and space is not reserved.
  wire launch = ctrl_wr && !program_busy_reg && key == `KEY_LAUNCH &&
    last_key_reg == `KEY_UNLOCK && new_space != `SPACE_RSVD;
  localparam ST_IDLE = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_PROG = 2'h2;
  reg [1:0] state_reg;
  reg [31:0] timer_reg;
  reg [6:0] byte_reg;
  // Control bits; writes during programming are refused so that the map
  // and target cannot shift under a running operation.
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_map_select_reg <= 1'b0;
      space_select_reg <= `SPACE_USER;
      last_key_reg <= 4'h0;
      boot_space_select_reg <= 1'b0;
      ext_ram_select_reg <= 1'b0;
      target_reg <= `SPACE_USER;
    end else if (!program_busy_reg) begin
      if (ctrl_wr) begin
        latch_map_select_reg <= wr_d[`FC_MAP_BIT];
        space_select_reg <= new_space;
        // Any key other than 5 clears the sequence; A after 5 consumes it.
        last_key_reg <= (key == `KEY_UNLOCK) ? key : 4'h0;
        if (launch) begin
          target_reg <= new_space;
        end
      end
      if (wr_lane0 && wr_a == `ADDR_AUX_ONE) begin
        boot_space_select_reg <= wr_d[`AUX_ONE_BOOT_BIT];
      end
      if (wr_lane0 && wr_a == `ADDR_AUX) begin
        ext_ram_select_reg <= wr_d[`AUX_EXT_RAM_SELECT_BIT];
      end
    end
  end
  // ----------------------------------------
  // Data writes: latch load or external RAM
  // ----------------------------------------
  wire to_latch = latch_map_select_reg && !program_busy_reg &&
    data_pointer <= `LATCH_TOP;
  wire latch_wr = data_wr && to_latch;
  always @(posedge aclk) begin
    if (!aresetn) begin
      xram_wr <= 1'b0;
      xram_addr <= 16'h0000;
      xram_wdata <= 8'h00;
      page_reg <= 8'h00;
    end else begin
      xram_wr <= data_wr && !to_latch;
      xram_addr <= data_pointer;
      xram_wdata <= data_wdata;
      if (latch_wr) begin
        page_reg <= data_pointer[14:7];
      end
    end
  end
  wire [7:0] cl_data;
  wire cl_loaded;
  column_latch_mem #(
    .DEPTH(`PAGE_BYTES),
    .AW(7)
  ) u_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(latch_wr),
    .wr_addr(data_pointer[6:0]),
    .wr_data(data_wdata),
    .rd_addr(byte_reg),
    .rd_data(cl_data),
    .rd_loaded(cl_loaded),
    .clear_all(state_reg == ST_PROG && timer_reg == 32'h00000000)
  );
  // ----------------------------------------
  // Erase then program sequence
  // ----------------------------------------
  // Erase marks loaded user and extra-row bytes blank; program writes them. Each byte walk
  // lasts 128 cycles inside a phase timed by its own count.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h00000000;
      byte_reg <= 7'h00;
      program_busy_reg <= 1'b0;
      cpu_idle <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (launch) begin
            state_reg <= ST_ERASE;
            timer_reg <= ERASE_CYCLES - 1;
            byte_reg <= 7'h00;
            program_busy_reg <= 1'b1;
            cpu_idle <= 1'b1;
          end
        end
        ST_ERASE: begin
          byte_reg <= byte_reg + 7'h01;
          if (timer_reg == 32'h00000000) begin
            state_reg <= ST_PROG;
            timer_reg <= PROG_CYCLES - 1;
            byte_reg <= 7'h00;
          end else begin
            timer_reg <= timer_reg - 32'h00000001;
          end
        end
        ST_PROG: begin
          byte_reg <= byte_reg + 7'h01;
          if (timer_reg == 32'h00000000) begin
            state_reg <= ST_IDLE;
            program_busy_reg <= 1'b0;
            cpu_idle <= 1'b0;
          end else begin
            timer_reg <= timer_reg - 32'h00000001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // Latch read data lag the byte index by one cycle.
  reg [6:0] byte_d_reg;
  reg walk_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      byte_d_reg <= 7'h00;
      walk_reg <= 1'b0;
    end else begin
      byte_d_reg <= byte_reg;
      walk_reg <= state_reg != ST_IDLE;
    end
  end
  wire [14:0] user_idx = {page_reg, byte_d_reg};
  wire erase_now = walk_reg && state_reg == ST_ERASE && cl_loaded;
  wire prog_now = walk_reg && state_reg == ST_PROG && cl_loaded;
  // Only loaded locations are touched; others keep their contents.
  always @(posedge aclk) begin
    if (erase_now || prog_now) begin
      if (target_reg == `SPACE_USER) begin
        user_mem[user_idx] <= erase_now ? 8'hFF : cl_data;
      end else if (target_reg == `SPACE_EXTRA_ROW_SPACE) begin
        extra_row_space_mem[byte_d_reg] <= erase_now ? 8'hFF : cl_data;
      end
    end
  end
  // Security byte: only the upper nibble follows software.
  always @(posedge aclk) begin
    if (!aresetn) begin
      security_reg <= 8'hFF;
    end else if (prog_now && target_reg == `SPACE_SEC &&
        byte_d_reg == 7'h00) begin
      security_reg <= {cl_data[7:4], security_reg[3:0]};
    end
  end
  // ----------------------------------------
  // Code-space reads
  // ----------------------------------------
  wire in_boot = boot_space_select_reg && code_addr >= `BOOT_BASE;
  wire [15:0] boot_off = code_addr - `BOOT_BASE;
  always @(posedge aclk) begin
    if (!aresetn) begin
      code_valid <= 1'b0;
      code_rdata <= 8'h00;
    end else begin
      // No fetch is served while busy.
      code_valid <= code_rd && !program_busy_reg;
      if (code_rd) begin
        if (in_boot) begin
          code_rdata <= boot_mem[boot_off[11:0]];
        end else begin
          case (space_select_reg)
            `SPACE_EXTRA_ROW_SPACE: code_rdata <= extra_row_space_mem[code_addr[6:0]];
            `SPACE_SEC: code_rdata <= security_reg;
            default: code_rdata <= code_addr[15] ? 8'hFF :
              user_mem[code_addr[14:0]];
          endcase
        end
      end
    end
  end
endmodule

//--- tb/flash_seq_checker.sv
// Checker for the flash program sequencer, bound to its top module.
// Assumes one clock aclk and a synchronous active-low reset aresetn.
`timescale 1ns/1ns
module flash_seq_checker #(
  parameter ERASE_CYCLES = 200,
  parameter PROG_CYCLES = 200
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus signals
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [3:0] s_axi_araddr,
  input wire [31:0] s_axi_rdata,
  // CPU side signals
  input wire data_wr,
  input wire [15:0] data_pointer,
  input wire xram_wr,
  input wire [15:0] xram_addr,
  input wire code_rd,
  input wire code_valid,
  input wire cpu_idle
);
  // ----------------------------------------
  // Idle length counter
  // ----------------------------------------
  // Idle spans the erase count plus the program count, one clock each.
  localparam int TOTAL = ERASE_CYCLES + PROG_CYCLES;
  logic [31:0] idle_cnt;
  // Counts consecutive idle cycles so long holds need no repetition.
  always @(posedge aclk) begin
    if (!aresetn) idle_cnt <= 32'h0;
    else if (cpu_idle) idle_cnt <= idle_cnt + 32'h1;
    else idle_cnt <= 32'h0;
  end
  default clocking cb_main @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_launch;
    $rose(cpu_idle);
  endsequence
  sequence s_busy_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0;
  endsequence
  property p_no_fetch;
    cpu_idle && code_rd |=> !code_valid;
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch while busy");
  property p_valid_cause;
    code_valid |-> $past(code_rd);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("stray fetch");
  property p_xram_cause;
    xram_wr |-> $past(data_wr) && xram_addr == $past(data_pointer);
  endproperty
  a_xram_cause: assert property (p_xram_cause) else $error("bad xram");
  property p_high_range;
    data_wr && data_pointer > 16'h7FFF |=> xram_wr;
  endproperty
  a_high_range: assert property (p_high_range) else $error("high lost");
  property p_launch_edge;
    s_launch |-> $rose(s_axi_bvalid);
  endproperty
  a_launch_edge: assert property (p_launch_edge) else $error("odd launch");
  property p_idle_len;
    $fell(cpu_idle) |-> idle_cnt == TOTAL;
  endproperty
  a_idle_len: assert property (p_idle_len) else $error("idle length");
  property p_idle_max;
    idle_cnt <= TOTAL;
  endproperty
  a_idle_max: assert property (p_idle_max) else $error("idle too long");
  property p_busy_rd;
    s_busy_rd |=> s_axi_rdata[0] == $past(cpu_idle);
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy bit");
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stands: assert property (p_b_stands) else $error("bvalid dropped");
endmodule
bind flash_program_sequencer flash_seq_checker #(
  .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rdata(s_axi_rdata), .data_wr(data_wr), .data_pointer(data_pointer),
  .xram_wr(xram_wr), .xram_addr(xram_addr), .code_rd(code_rd),
  .code_valid(code_valid), .cpu_idle(cpu_idle));

//--- tb/cpu_core_model.sv
// CPU core model: issues data writes and code reads as one-cycle strobes.
// Assumes tasks are entered just after a rising edge of aclk.
`timescale 1ns/1ns
module cpu_core_model (
  // Clock
  input wire aclk,
  // Data write side
  output logic data_wr,
  output logic [15:0] data_pointer,
  output logic [7:0] data_wdata,
  // Code read side
  output logic code_rd,
  output logic [15:0] code_addr,
  input wire code_valid,
  input wire [7:0] code_rdata,
  input wire cpu_idle
);
  // No interrupt source exists here, so idle is never ended early.
  initial begin
    data_wr = 1'b0;
    data_pointer = 16'h0;
    data_wdata = 8'h0;
    code_rd = 1'b0;
    code_addr = 16'h0;
  end
  // One data write; released lines show the inverse, never a stale copy.
  task dwr(input logic [15:0] a, input logic [7:0] d);
    data_wr <= 1'b1;
    data_pointer <= a;
    data_wdata <= d;
    @(posedge aclk);
    data_wr <= 1'b0;
    data_pointer <= ~a;
    data_wdata <= ~d;
    @(posedge aclk);
  endtask
  // One code read; the answer is sampled one edge after the request.
  task crd(input logic [15:0] a, output logic ok, output logic [7:0] d);
    code_rd <= 1'b1;
    code_addr <= a;
    @(posedge aclk);
    code_rd <= 1'b0;
    code_addr <= ~a;
    @(posedge aclk);
    ok = code_valid;
    d = code_rdata;
  endtask
endmodule

//--- tb/test_flash_program_sequencer.sv
// Testbench for the flash program sequencer, with a CPU core model.
// Assumes the design header is on the include path; short phase counts.
`timescale 1ns/1ns
`include "flash_seq_consts.vh"
module test_flash_program_sequencer;
  localparam int EC = 200;
  localparam int PC = 200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, data_wr, code_rd, xram_wr, code_valid, cpu_idle, ok;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] data_pointer, code_addr, xram_addr;
  logic [7:0] data_wdata, code_rdata, xram_wdata, cb;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  // Free-running core clock at 10 MHz.
  always #50 aclk = ~aclk;
  flash_program_sequencer #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC))
      flash_program_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .data_wr(data_wr), .data_pointer(data_pointer), .data_wdata(data_wdata),
    .xram_wr(xram_wr), .xram_addr(xram_addr), .xram_wdata(xram_wdata),
    .code_rd(code_rd), .code_addr(code_addr), .code_valid(code_valid),
    .code_rdata(code_rdata), .cpu_idle(cpu_idle));
  cpu_core_model cpu_core_model_i (
    .aclk(aclk), .data_wr(data_wr), .data_pointer(data_pointer),
    .data_wdata(data_wdata), .code_rd(code_rd), .code_addr(code_addr),
    .code_valid(code_valid), .code_rdata(code_rdata), .cpu_idle(cpu_idle));
  // ----------------------------------------
  // Comparison, verdict and bus tasks
  // ----------------------------------------
  task check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task timeout;
    miscompares++;
    $display("BAD timeout expected answer seen none");
    wrap_up;
  endtask
  // Both write halves offered together, each released once taken.
  task axi_write(input logic [3:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) timeout;
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task axi_read(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) timeout;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Unlock and launch one space, poke the busy window, wait for the end.
  task launch(input logic [1:0] sp);
    axi_write(`ADDR_FLASH_CTRL, {24'h0, 4'h5, 1'b1, sp, 1'b0});
    axi_read(`ADDR_FLASH_CTRL);
    check("key_read", rd[7:4], 4'h5);
    axi_write(`ADDR_FLASH_CTRL, {24'h0, 4'hA, 1'b1, sp, 1'b0});
    check("idle_on", cpu_idle, 1'b1);
    axi_read(`ADDR_FLASH_CTRL);
    check("busy_on", rd[0], 1'b1);
    cpu_core_model_i.crd(16'h0000, ok, cb);
    check("no_fetch", ok, 1'b0);
    axi_write(`ADDR_FLASH_CTRL, 32'h0);
    axi_read(`ADDR_FLASH_CTRL);
    check("busy_kept", rd[0], 1'b1);
    for (n = 0; n < 1000 && cpu_idle === 1'b1; n++) @(posedge aclk);
    if (n == 1000) timeout;
    axi_read(`ADDR_FLASH_CTRL);
    check("busy_off", rd[0], 1'b0);
  endtask
  // A control write that must not start programming.
  task no_launch(input logic [7:0] v);
    axi_write(`ADDR_FLASH_CTRL, {24'h0, v});
    repeat (2) @(posedge aclk);
    check("no_launch", cpu_idle, 1'b0);
  endtask
  task fetch(input logic [15:0] a, input logic [7:0] exp);
    cpu_core_model_i.crd(a, ok, cb);
    check("fetch_ok", ok, 1'b1);
    check("fetch_data", cb, exp);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(`ADDR_FLASH_CTRL);
    check("flash_control_reg_reset", rd, 32'h0);
    axi_read(`ADDR_AUX_ONE);
    check("aux_one_reset", rd, 32'h0);
    axi_read(`ADDR_AUX);
    check("aux_reset", rd, 32'h0);
    axi_read(`ADDR_STATUS);
    check("unmapped", rsp, 2'h2);
    axi_write(`ADDR_STATUS, 32'h0);
    check("unmapped_wr", rsp, 2'h2);
    cpu_core_model_i.dwr(16'h1234, 8'h5A);
    check("plain_write", xram_wr, 1'b1);
    check("plain_addr", xram_addr, 16'h1234);
    check("plain_data", xram_wdata, 8'h5A);
    axi_write(`ADDR_AUX, 32'h2);
    axi_write(`ADDR_FLASH_CTRL, 32'h08);
    cpu_core_model_i.dwr(16'h0106, 8'h11);
    check("latch_steer", xram_wr, 1'b0);
    cpu_core_model_i.dwr(16'h8000, 8'h22);
    check("above_latch", xram_wr, 1'b1);
    launch(`SPACE_USER);
    cpu_core_model_i.dwr(16'h0105, 8'h3C);
    launch(`SPACE_USER);
    fetch(16'h0105, 8'h3C);
    fetch(16'h0106, 8'h11);
    no_launch(8'hA8);
    no_launch(8'h58);
    no_launch(8'h38);
    no_launch(8'hA8);
    no_launch(8'h5E);
    no_launch(8'hAE);
    cpu_core_model_i.dwr(16'h0005, 8'h77);
    launch(`SPACE_EXTRA_ROW_SPACE);
    axi_write(`ADDR_FLASH_CTRL, 32'h02);
    fetch(16'hFF85, 8'h77);
    axi_write(`ADDR_FLASH_CTRL, 32'h0C);
    cpu_core_model_i.dwr(16'h0000, 8'h5A);
    launch(`SPACE_SEC);
    axi_write(`ADDR_FLASH_CTRL, 32'h04);
    fetch(16'h0000, 8'h5F);
    axi_write(`ADDR_FLASH_CTRL, 32'h00);
    fetch(16'hFF85, 8'hFF);
    axi_write(`ADDR_AUX_ONE, 32'h20);
    axi_read(`ADDR_AUX_ONE);
    check("boot_sel", rd[5], 1'b1);
    fetch(16'hF3FF, 8'hFF);
    cpu_core_model_i.crd(16'hF400, ok, cb);
    check("boot_ok", ok, 1'b1);
    check("boot_map", cb, 8'h00);
    wrap_up;
  end
endmodule
